/* File: core/sync_serial_pkg.sv */
// Purpose: constants for the clocked serial port block
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes:   8-bit registers sit in the low byte; upper bits read zero
package sync_serial_pkg;
  // register byte offsets
  localparam logic [4:0] OFS_RX_CTRL   = 5'h00;
  localparam logic [4:0] OFS_RX_DATA   = 5'h04;
  localparam logic [4:0] OFS_TX_CTRL   = 5'h08;
  localparam logic [4:0] OFS_BAUD_CTRL = 5'h0C;
  localparam logic [4:0] OFS_DIV_HIGH  = 5'h10;
  localparam logic [4:0] OFS_DIV_LOW   = 5'h14;
  localparam logic [4:0] OFS_TX_DATA   = 5'h18;
  localparam logic [4:0] OFS_INT_CTRL  = 5'h1C;
  // rx_control_status fields
  localparam int RC_SERIAL_EN  = 7;
  localparam int RC_RX_NINTH   = 6;
  localparam int RC_SINGLE_RX  = 5;
  localparam int RC_CONT_RX    = 4;
  localparam int RC_ADDR_DET   = 3;
  localparam int RC_FRAME_ERR  = 2;
  localparam int RC_OVERRUN    = 1;
  localparam int RC_NINTH_BIT  = 0;
  // tx_control_status fields
  localparam int TC_CLK_SRC    = 7;
  localparam int TC_TX_NINTH   = 6;
  localparam int TC_TX_EN      = 5;
  localparam int TC_CLOCKED    = 4;
  localparam int TC_SEND_BREAK = 3;
  localparam int TC_HIGH_SPEED = 2;
  localparam int TC_SHIFT_EMPT = 1;
  localparam int TC_NINTH_BIT  = 0;
  // baud_control fields
  localparam int BC_AB_OVF     = 7;
  localparam int BC_RX_IDLE    = 6;
  localparam int BC_DATA_INV   = 5;
  localparam int BC_CLK_INV    = 4;
  localparam int BC_WIDE       = 3;
  localparam int BC_WAKE       = 1;
  localparam int BC_AB_EN      = 0;
  // int_control fields
  localparam int IC_RX_DONE    = 0;
  localparam int IC_TX_READY   = 1;
  localparam int IC_RX_IE      = 2;
  localparam int IC_TX_IE      = 3;
  localparam int IC_PERIPH_IE  = 4;
  // reset values
  localparam logic [7:0] RST_RX_CTRL   = 8'h00;
  localparam logic [7:0] RST_TX_CTRL   = 8'h00;
  localparam logic [7:0] RST_BAUD_CTRL = 8'h00;
  localparam logic [7:0] RST_INT_CTRL  = 8'h00;
  localparam logic [7:0] RST_DIV       = 8'h00;
  // character lengths and queue depth
  localparam logic [3:0] LEN_NARROW = 4'h8;
  localparam logic [3:0] LEN_WIDE   = 4'h9;
  localparam logic [1:0] QUEUE_DEPTH = 2'h2;
  // reserved and unimplemented bits
  localparam logic [7:0] BAUD_WR_MASK = 8'h3B;
endpackage

/* File: core/sync_serial_port.sv */
// Purpose: clocked serial port, master receive and slave transmit
// Assumes: clk at 200 MHz, pin inputs synchronous to clk
// Notes:   one clock domain; the shift clock is generated or sampled
`timescale 1ns/1ps
`default_nettype none

module sync_serial_port
  import sync_serial_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // avalon-mm slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // clock pin
  input  wire logic        clock_pin_in,
  output logic             clock_pin_out,
  output logic             clock_pin_oe,
  // data pin
  input  wire logic        data_pin_in,
  output logic             data_pin_out,
  output logic             data_pin_oe,
  // interrupt request
  output logic             irq
);

  function automatic logic [3:0] char_len(input logic ninth);
    char_len = ninth ? LEN_WIDE : LEN_NARROW;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_r;
  logic rst_n_r;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers and state
  logic [7:0]  rx_ctrl_r;
  logic [7:0]  tx_ctrl_r;
  logic [7:0]  baud_ctrl_r;
  logic [7:0]  int_ctrl_r;
  logic [7:0]  div_high_r;
  logic [7:0]  div_low_r;
  logic [8:0]  tx_hold_r;
  logic        tx_hold_full_r;
  logic [8:0]  tx_shift_reg_r;
  logic [3:0]  tx_cnt_r;
  logic        tx_busy_r;
  logic [8:0]  rx_shift_reg_r;
  logic [3:0]  rx_cnt_r;
  logic [8:0]  queue_r [0:1];
  logic [1:0]  q_count_r;
  logic        q_head_r;
  logic        overrun_r;
  logic        overrun_single_r;
  logic [16:0] baud_cnt_r;
  logic        phase_r;
  logic        clk_prev_r;

  logic serial_en;
  logic clocked;
  logic master;
  logic rx_req;
  logic nine_rx;
  logic clk_idle;
  logic wr_acc;
  logic rd_acc;
  logic pop;
  logic tx_data_wr;
  logic rx_run;
  logic tx_go;
  logic master_run;
  logic gen_term;
  logic lead;
  logic trail;
  logic rx_done_char;
  logic push;
  logic [8:0]  rx_next;
  logic [8:0]  rx_char;
  logic [15:0] divisor;

  assign serial_en = rx_ctrl_r[RC_SERIAL_EN];
  assign clocked   = tx_ctrl_r[TC_CLOCKED] & serial_en;
  assign master    = tx_ctrl_r[TC_CLK_SRC];
  assign rx_req    = rx_ctrl_r[RC_SINGLE_RX] | rx_ctrl_r[RC_CONT_RX];
  assign nine_rx   = rx_ctrl_r[RC_RX_NINTH];
  assign clk_idle  = baud_ctrl_r[BC_CLK_INV];
  assign wr_acc    = write & ~waitrequest;
  assign rd_acc    = read & ~waitrequest;
  assign pop       = rd_acc & (address == OFS_RX_DATA) & (q_count_r != 2'h0);
  assign tx_data_wr = wr_acc & (address == OFS_TX_DATA);

  // transmitter armed only when enabled, clocked, and not receiving
  assign tx_go  = clocked & tx_ctrl_r[TC_TX_EN] & ~rx_req;
  assign rx_run = clocked & master & rx_req & ~overrun_r;
  assign master_run = clocked & master & (tx_busy_r | rx_run);

  // baud divisor, 16-bit pair or low byte only
  assign divisor  = baud_ctrl_r[BC_WIDE] ? {div_high_r, div_low_r}
                                         : {8'h00, div_low_r};
  assign gen_term = master_run & (baud_cnt_r == {divisor, 1'b1});

  // edges from the generator or from the external master
  always_comb
  begin
    if (master)
    begin
      lead  = gen_term & ~phase_r;
      trail = gen_term & phase_r;
    end
    else
    begin
      lead  = clocked & (clock_pin_in != clk_prev_r) & (clock_pin_in != clk_idle);
      trail = clocked & (clock_pin_in != clk_prev_r) & (clock_pin_in == clk_idle);
    end
  end

  assign rx_next = {data_pin_in ^ baud_ctrl_r[BC_DATA_INV], rx_shift_reg_r[8:1]};
  assign rx_char = nine_rx ? rx_next : {1'b0, rx_next[8:1]};
  assign rx_done_char = rx_run & trail & (rx_cnt_r == char_len(nine_rx) - 4'h1);
  assign push = rx_done_char & ((q_count_r != QUEUE_DEPTH) | pop);

  ////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, then the access completes
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      waitrequest <= 1'b1;
    else
      waitrequest <= ~((read | write) & waitrequest);
  end

  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      readdata <= 32'h0000_0000;
    else if (read & waitrequest)
    begin
      readdata <= 32'h0000_0000;
      if (address == OFS_RX_CTRL)
        readdata[7:0] <= {rx_ctrl_r[7:3], 1'b0, overrun_r,
                          queue_r[q_head_r][8]};
      else if (address == OFS_RX_DATA)
        readdata[7:0] <= queue_r[q_head_r][7:0];
      else if (address == OFS_TX_CTRL)
        readdata[7:0] <= {tx_ctrl_r[7:2], ~tx_busy_r, tx_ctrl_r[0]};
      else if (address == OFS_BAUD_CTRL)
        readdata[7:0] <= {1'b0, ~rx_run, baud_ctrl_r[5:3], 1'b0,
                          baud_ctrl_r[1:0]};
      else if (address == OFS_DIV_HIGH)
        readdata[7:0] <= div_high_r;
      else if (address == OFS_DIV_LOW)
        readdata[7:0] <= div_low_r;
      else if (address == OFS_INT_CTRL)
        readdata[7:0] <= {3'h0, int_ctrl_r[4:2], ~tx_hold_full_r,
                          q_count_r != 2'h0};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      rx_ctrl_r <= RST_RX_CTRL;
    else
    begin
      if (rx_done_char & ~rx_ctrl_r[RC_CONT_RX])
        rx_ctrl_r[RC_SINGLE_RX] <= 1'b0;
      if (wr_acc & (address == OFS_RX_CTRL))
        rx_ctrl_r[7:3] <= writedata[7:3];
    end
  end

  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      tx_ctrl_r   <= RST_TX_CTRL;
      baud_ctrl_r <= RST_BAUD_CTRL;
      int_ctrl_r  <= RST_INT_CTRL;
      div_high_r  <= RST_DIV;
      div_low_r   <= RST_DIV;
    end
    else if (wr_acc)
    begin
      if (address == OFS_TX_CTRL)
        tx_ctrl_r <= {writedata[7:2], 1'b0, writedata[0]};
      else if (address == OFS_BAUD_CTRL)
        baud_ctrl_r <= writedata[7:0] & BAUD_WR_MASK;
      else if (address == OFS_INT_CTRL)
        int_ctrl_r <= {3'h0, writedata[4:2], 2'h0};
      else if (address == OFS_DIV_HIGH)
        div_high_r <= writedata[7:0];
      else if (address == OFS_DIV_LOW)
        div_low_r <= writedata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shift clock generator and slave edge tracking
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      baud_cnt_r <= 17'h0_0000;
      phase_r    <= 1'b0;
      clk_prev_r <= 1'b0;
    end
    else
    begin
      clk_prev_r <= clock_pin_in;
      if (!master_run)
      begin
        baud_cnt_r <= 17'h0_0000;
        phase_r    <= 1'b0;
      end
      else if (gen_term)
      begin
        baud_cnt_r <= 17'h0_0000;
        phase_r    <= ~phase_r;
      end
      else
        baud_cnt_r <= baud_cnt_r + 17'h0_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit holding and shift registers
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      tx_hold_r      <= 9'h000;
      tx_hold_full_r <= 1'b0;
      tx_shift_reg_r <= 9'h000;
      tx_cnt_r       <= 4'h0;
      tx_busy_r      <= 1'b0;
    end
    else if (!serial_en)
    begin
      tx_hold_full_r <= 1'b0;
      tx_busy_r      <= 1'b0;
      tx_cnt_r       <= 4'h0;
    end
    else
    begin
      if (tx_data_wr)
      begin
        tx_hold_r      <= {tx_ctrl_r[TC_NINTH_BIT], writedata[7:0]};
        tx_hold_full_r <= 1'b1;
      end
      if (tx_busy_r & lead)
      begin
        tx_shift_reg_r <= {1'b0, tx_shift_reg_r[8:1]};
        tx_cnt_r       <= tx_cnt_r - 4'h1;
      end
      if (tx_busy_r & trail & (tx_cnt_r == 4'h0))
        tx_busy_r <= 1'b0;
      else if (!tx_busy_r & tx_hold_full_r & tx_go & !tx_data_wr)
      begin
        tx_shift_reg_r <= tx_hold_r;
        tx_cnt_r       <= char_len(tx_ctrl_r[TC_TX_NINTH]);
        tx_busy_r      <= 1'b1;
        tx_hold_full_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive shifter, two-deep queue, overrun
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      rx_shift_reg_r <= 9'h000;
      rx_cnt_r       <= 4'h0;
    end
    else if (!rx_run)
      rx_cnt_r <= 4'h0;
    else if (rx_done_char)
      rx_cnt_r <= 4'h0;
    else if (trail)
    begin
      rx_shift_reg_r <= rx_next;
      rx_cnt_r       <= rx_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      queue_r[0] <= 9'h000;
      queue_r[1] <= 9'h000;
      q_count_r  <= 2'h0;
      q_head_r   <= 1'b0;
    end
    else if (!serial_en)
    begin
      q_count_r <= 2'h0;
      q_head_r  <= 1'b0;
    end
    else
    begin
      if (push)
        queue_r[q_head_r ^ (q_count_r[0] & ~pop)] <= rx_char;
      if (pop)
        q_head_r <= ~q_head_r;
      if (push & !pop)
        q_count_r <= q_count_r + 2'h1;
      else if (pop & !push)
        q_count_r <= q_count_r - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      overrun_r        <= 1'b0;
      overrun_single_r <= 1'b0;
    end
    else if (rx_done_char & !push)
    begin
      overrun_r        <= 1'b1;
      overrun_single_r <= ~rx_ctrl_r[RC_CONT_RX];
    end
    else if (!serial_en | (!rx_ctrl_r[RC_CONT_RX] & !overrun_single_r)
             | (overrun_single_r & pop))
      overrun_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // pins and interrupt
  always_ff @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      clock_pin_out <= 1'b0;
      clock_pin_oe  <= 1'b0;
      data_pin_out  <= 1'b0;
      data_pin_oe   <= 1'b0;
      irq           <= 1'b0;
    end
    else
    begin
      clock_pin_out <= clk_idle ^ (master_run & ~gen_term ? phase_r : master_run & ~phase_r);
      clock_pin_oe  <= clocked & master;
      data_pin_oe   <= tx_go;
      if (tx_busy_r & lead)
        data_pin_out <= tx_shift_reg_r[0] ^ baud_ctrl_r[BC_DATA_INV];
      irq <= ((q_count_r != 2'h0) & int_ctrl_r[IC_RX_IE])
           | (~tx_hold_full_r & int_ctrl_r[IC_TX_IE]
              & int_ctrl_r[IC_PERIPH_IE]);
    end
  end

endmodule // sync_serial_port

`default_nettype wire

/* File: sim/sync_serial_peer.sv */
// Purpose: far side model, clock slave for receive, clock master for transmit
// Assumes: clock_invert left at zero; data_invert folded into expectations
// Notes:   undriven data line toggles each cycle
`timescale 1ns/1ps
`default_nettype none
module sync_serial_peer (
  // clock
  input  wire logic       clk,
  // device as master
  input  wire logic       clock_pin_out,
  input  wire logic       clock_pin_oe,
  input  wire logic [3:0] nbits,
  input  wire logic       restart,
  output logic            data_pin_in,
  // device as slave
  input  wire logic       data_pin_out,
  output logic            clock_pin_in
);
  logic [8:0] words [4];
  logic [3:0] bit_r = 4'h0;
  logic [1:0] chr_r = 2'h0;
  logic       ck_r  = 1'b0;

  initial data_pin_in = 1'b0;
  initial clock_pin_in = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    ck_r <= clock_pin_out;
    if (restart)
    begin
      bit_r <= 4'h0;
      chr_r <= 2'h0;
    end
    else if (!clock_pin_oe)
      data_pin_in <= ~data_pin_in;
    else if (clock_pin_out && !ck_r)
    begin
      data_pin_in <= words[chr_r][bit_r];
      bit_r <= (bit_r == nbits - 4'h1) ? 4'h0 : bit_r + 4'h1;
      if (bit_r == nbits - 4'h1)
        chr_r <= chr_r + 2'h1;
    end
  end

  // clock idles low, one pulse per bit, sampled at the trailing edge
  task automatic clock_char(input int n, output logic [8:0] w);
    w = 9'h0;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      clock_pin_in <= 1'b1;
      repeat (4) @(posedge clk);
      w[i] = data_pin_out;
      clock_pin_in <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule // sync_serial_peer
`default_nettype wire

/* File: sim/sync_serial_port_properties.sv */
// Purpose: port-level properties of the clocked serial port
// Assumes: bound to the top module, one clock domain
// Notes:   bus handshake, pin enable and shift clock relations only
`timescale 1ns/1ps
`default_nettype none
module sync_serial_port_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // avalon-mm slave
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // pins
  input wire logic        clock_pin_in,
  input wire logic        clock_pin_out,
  input wire logic        clock_pin_oe,
  input wire logic        data_pin_out,
  input wire logic        data_pin_oe
);
  logic [2:0] since_wr_r;
  logic [2:0] since_ck_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////////
  // cycles since a write took effect
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      since_wr_r <= 3'h7;
    else if (write && !waitrequest)
      since_wr_r <= 3'h0;
    else if (since_wr_r != 3'h7)
      since_wr_r <= since_wr_r + 3'h1;
  end
  // cycles since the external shift clock moved
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      since_ck_r <= 3'h7;
    else if ($changed(clock_pin_in))
      since_ck_r <= 3'h0;
    else if (since_ck_r != 3'h7)
      since_ck_r <= since_ck_r + 3'h1;
  end

  sequence s_req;
    (read || write) && waitrequest;
  endsequence
  sequence s_ack_once;
    !waitrequest ##1 waitrequest;
  endsequence

  chk_req_answered: assert property (s_req |=> s_ack_once)
    else $error("bus request not answered with one low wait cycle");
  chk_ack_needs_req: assert property (!waitrequest |-> (read || write))
    else $error("wait dropped without a request");
  chk_rdata_upper: assert property (!waitrequest && read |-> readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_rdata_holds: assert property ($changed(readdata) |-> $past(read))
    else $error("read data changed without a read");
  chk_clk_oe_write: assert property ($changed(clock_pin_oe) |-> since_wr_r <= 3'h2)
    else $error("clock pin enable moved without a register write");
  chk_data_oe_write: assert property ($changed(data_pin_oe) && !clock_pin_oe |-> since_wr_r <= 3'h2)
    else $error("data pin enable moved without a register write");
  chk_master_phase: assert property (clock_pin_oe && $changed(clock_pin_out) |=> $stable(clock_pin_out))
    else $error("master shift clock phase shorter than two cycles");
  chk_slave_edge: assert property ($changed(data_pin_out) && $past(data_pin_oe) && data_pin_oe
      && !clock_pin_oe |-> since_ck_r <= 3'h3)
    else $error("slave data moved away from a clock edge");
endmodule // sync_serial_port_checker
`default_nettype wire

/* File: sim/sync_serial_port_test.sv */
// Purpose: self-checking bench for the clocked serial port
// Assumes: peer model on the pins, bounded waits on every handshake
// Notes:   master receive and slave transmit only
`timescale 1ns/1ps
`default_nettype none
module sync_serial_port_test
  import sync_serial_pkg::*;
;
  logic        clk = 1'b0, resetn = 1'b0, read = 1'b0, write = 1'b0, restart = 1'b0;
  logic [4:0]  address = 5'h00;
  logic [31:0] writedata = 32'h0, readdata;
  logic        waitrequest, irq, clock_pin_out, clock_pin_oe, data_pin_out, data_pin_oe;
  logic        clock_pin_in, data_pin_in, ck_seen = 1'b0;
  logic [3:0]  nbits = 4'h8;
  logic [8:0]  word;
  int          error_cnt = 0, compares = 0, rises = 0, cyc = 0, last_rise = 0, gap = 0;

  always #2.5 clk = ~clk;

  sync_serial_port DUT (
    .clk(clk), .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .clock_pin_in(clock_pin_in), .clock_pin_out(clock_pin_out),
    .clock_pin_oe(clock_pin_oe), .data_pin_in(data_pin_in),
    .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe), .irq(irq));
  sync_serial_peer PEER (
    .clk(clk), .clock_pin_out(clock_pin_out), .clock_pin_oe(clock_pin_oe),
    .nbits(nbits), .restart(restart), .data_pin_in(data_pin_in),
    .data_pin_out(data_pin_out), .clock_pin_in(clock_pin_in));

  ////////////////////////////////////////////////////////////////////////////
  // master clock edge counter and period
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    ck_seen <= clock_pin_out;
    if (restart)
      rises <= 0;
    else if (clock_pin_out && !ck_seen)
    begin
      rises <= rises + 1;
      gap <= cyc - last_rise;
      last_rise <= cyc;
    end
  end

  task automatic report_and_stop();
    if (error_cnt == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_ack();
    int n;
    n = 0;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    if (waitrequest !== 1'b0)
    begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    address   <= a;
    writedata <= {24'h0, d};
    write     <= 1'b1;
    wait_ack();
    write <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk);
    address <= a;
    read    <= 1'b1;
    wait_ack();
    read <= 1'b0;
    check(readdata, {24'h0, exp});
  endtask

  task automatic arm(input logic [3:0] n);
    @(posedge clk);
    nbits   <= n;
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
  endtask

  task automatic wait_rises(input int k);
    int n;
    n = 0;
    while (rises < k && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    if (rises < k)
    begin
      error_cnt++;
      report_and_stop();
    end
    repeat (20) @(posedge clk);
  endtask

  initial
  begin
    PEER.words[0] = 9'h0A5;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(OFS_RX_CTRL, RST_RX_CTRL);
    rd(OFS_TX_CTRL, RST_TX_CTRL | 8'h02);
    rd(OFS_BAUD_CTRL, RST_BAUD_CTRL | 8'h40);
    rd(OFS_INT_CTRL, 8'h02);
    wr(OFS_BAUD_CTRL, 8'hFF);
    rd(OFS_BAUD_CTRL, BAUD_WR_MASK | 8'h40);
    wr(OFS_BAUD_CTRL, 8'h00);
    wr(OFS_DIV_HIGH, 8'h01);
    wr(OFS_DIV_LOW, 8'h01);
    rd(OFS_DIV_HIGH, 8'h01);
    // single receive, master, high divisor byte unused
    wr(OFS_TX_CTRL, 8'h90);
    wr(OFS_RX_CTRL, 8'h80);
    wr(OFS_INT_CTRL, 8'h04);
    arm(4'h8);
    wr(OFS_RX_CTRL, 8'hA0);
    wait_rises(8);
    check(rises, 32'h8);
    check(gap, 32'h8);
    check(irq, 32'h1);
    rd(OFS_RX_CTRL, 8'h80);
    rd(OFS_INT_CTRL, 8'h07);
    rd(OFS_RX_DATA, 8'hA5);
    repeat (3) @(posedge clk);
    check(irq, 32'h0);
    // 16-bit divisor: phase of 2 * (0x101 + 1) cycles
    wr(OFS_BAUD_CTRL, 8'h08);
    arm(4'h8);
    wr(OFS_RX_CTRL, 8'hA0);
    wait_rises(2);
    check(gap, 32'h408);
    wr(OFS_RX_CTRL, 8'h80);
    wr(OFS_BAUD_CTRL, 8'h00);
    // nine-bit continuous receive into overrun
    PEER.words[0] = 9'h13C;
    PEER.words[1] = 9'h0C3;
    PEER.words[2] = 9'h1FF;
    arm(4'h9);
    wr(OFS_RX_CTRL, 8'hC0);
    wr(OFS_RX_CTRL, 8'hD0);
    wait_rises(27);
    rd(OFS_RX_CTRL, 8'hD3);
    rd(OFS_RX_DATA, 8'h3C);
    rd(OFS_RX_CTRL, 8'hD2);
    rd(OFS_RX_DATA, 8'hC3);
    rd(OFS_INT_CTRL, 8'h06);
    wr(OFS_RX_CTRL, 8'hC0);
    rd(OFS_RX_CTRL, 8'hC1);
    rd(OFS_BAUD_CTRL, 8'h40);
    check({clock_pin_oe, data_pin_oe}, 32'h2);
    wr(OFS_BAUD_CTRL, 8'h10);
    repeat (3) @(posedge clk);
    check(clock_pin_out, 32'h1);
    wr(OFS_BAUD_CTRL, 8'h00);
    wr(OFS_RX_CTRL, 8'h00);
    repeat (3) @(posedge clk);
    check(clock_pin_oe, 32'h0);
    // slave transmit
    wr(OFS_TX_CTRL, 8'h10);
    wr(OFS_RX_CTRL, 8'h80);
    repeat (3) @(posedge clk);
    check({clock_pin_oe, data_pin_oe}, 32'h0);
    wr(OFS_TX_CTRL, 8'h30);
    wr(OFS_INT_CTRL, 8'h18);
    repeat (3) @(posedge clk);
    check({clock_pin_oe, data_pin_oe, irq}, 32'h3);
    wr(OFS_TX_DATA, 8'h5A);
    wr(OFS_TX_DATA, 8'hC6);
    rd(OFS_INT_CTRL, 8'h18);
    rd(OFS_TX_CTRL, 8'h30);
    check(irq, 32'h0);
    PEER.clock_char(8, word);
    check(word, 32'h05A);
    repeat (3) @(posedge clk);
    rd(OFS_INT_CTRL, 8'h1A);
    check(irq, 32'h1);
    PEER.clock_char(8, word);
    check(word, 32'h0C6);
    repeat (3) @(posedge clk);
    rd(OFS_TX_CTRL, 8'h32);
    // data invert on: the peer sees every bit flipped
    wr(OFS_BAUD_CTRL, 8'h20);
    wr(OFS_TX_CTRL, 8'h71);
    wr(OFS_TX_DATA, 8'h81);
    PEER.clock_char(9, word);
    check(word, 32'h07E);
    // second reset in mid-run
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(OFS_TX_CTRL, RST_TX_CTRL | 8'h02);
    report_and_stop();
  end
endmodule // sync_serial_port_test

bind sync_serial_port sync_serial_port_checker CHK (
  .clk(clk), .resetn(resetn), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .clock_pin_in(clock_pin_in), .clock_pin_out(clock_pin_out),
  .clock_pin_oe(clock_pin_oe), .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe));
`default_nettype wire
